// ===== rtl/vig_host.v
// Purpose: Host-side interrupt glue and acknowledge sequencer for a UART
// Assumes: UART pin is asynchronous and synchronised here
// Notes:   Data bus split into out/oe; no tristate inside
`timescale 1ns/10ps
`include "vig_defines.vh"

module vig_host
#(
   parameter NPER = 8
)
(
   input  wire            clk_i,
   input  wire            reset_n_i,
   input  wire [NPER-1:0] uart_irq_n_i,
   input  wire            edge_irq_i,
   input  wire            mid_irq_i,
   input  wire            low_irq_i,
   input  wire            instr_done_i,
   input  wire            int_enable_i,
   output reg             vectored_irq_in_o,
   output reg             cpu_ack_n_o,
   output reg  [7:0]      data_o,
   output reg             data_oe_o,
   output reg             vec_taken_o,
   output reg  [15:0]     vec_addr_o,
   output reg  [2:0]      vec_prio_o
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function [7:0] vig_rst_op;
      input [2:0] idx;
      begin
         vig_rst_op = `VIG_RST_BASE_OP + ({5'h00, idx} * `VIG_RST_STEP);
      end
   endfunction

   function [15:0] vig_rst_addr;
      input [7:0] op;
      begin
         vig_rst_addr = `VIG_VEC_RST_BASE + {10'h000, op[5:3], 3'h0};
      end
   endfunction

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   localparam ST_IDLE   = 4'b0001;
   localparam ST_WAIT   = 4'b0010;
   localparam ST_ACK    = 4'b0100;
   localparam ST_DIRECT = 4'b1000;

   reg [3:0]      state_r;
   reg [3:0]      state_nxt;
   reg [2:0]      sel_r;
   reg [2:0]      sel_nxt;
   reg [3:0]      cnt_r;
   reg [3:0]      cnt_nxt;
   reg [NPER-1:0] grant_r;
   reg [NPER-1:0] grant_nxt;
   reg [7:0]      op_sel;
   integer        i;
   integer        j;

   // Grant in force: live pick while waiting, frozen once acknowledged
   wire [NPER-1:0] grant_now = (state_r == ST_WAIT) ? grant_nxt : grant_r;

   // ------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------
   reg [NPER-1:0] irq_s1_r;
   reg [NPER-1:0] irq_s2_r;
   reg [2:0]      dir_s1_r;
   reg [2:0]      dir_s2_r;
   reg            edge_d_r;
   reg            edge_pend_r;

   always @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         irq_s1_r    <= {NPER{1'b1}};
         irq_s2_r    <= {NPER{1'b1}};
         dir_s1_r    <= 3'h0;
         dir_s2_r    <= 3'h0;
         edge_d_r    <= 1'b0;
         edge_pend_r <= 1'b0;
      end
      else
      begin
         irq_s1_r <= uart_irq_n_i;
         irq_s2_r <= irq_s1_r;
         dir_s1_r <= {edge_irq_i, mid_irq_i, low_irq_i};
         dir_s2_r <= dir_s1_r;
         edge_d_r <= dir_s2_r[2];
         // Rising edge latched; set beats clear
         if (dir_s2_r[2] && !edge_d_r)
            edge_pend_r <= 1'b1;
         else if (state_r == ST_DIRECT && sel_r == `VIG_PRIO_EDGE)
            edge_pend_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Request combine
   // ------------------------------------------------------------
   wire vect_req = ~&irq_s2_r;

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   // Pending priority pick; level inputs and vectored line sampled live
   always @*
   begin
      sel_nxt = `VIG_PRIO_NONE;
      if (edge_pend_r)
         sel_nxt = `VIG_PRIO_EDGE;
      else if (dir_s2_r[1])
         sel_nxt = `VIG_PRIO_MID;
      else if (dir_s2_r[0])
         sel_nxt = `VIG_PRIO_LOW;
      else if (vect_req)
         sel_nxt = `VIG_PRIO_VECT;
   end

   // Lowest-index requester gets the buffer
   always @*
   begin
      grant_nxt = {NPER{1'b0}};
      for (i = NPER - 1; i >= 0; i = i - 1)
         if (!irq_s2_r[i])
            grant_nxt = {{(NPER-1){1'b0}}, 1'b1} << i;
   end

   always @*
   begin
      op_sel = 8'h00;
      for (j = 0; j < NPER; j = j + 1)
         if (grant_now[j])
            op_sel = vig_rst_op((NPER == 1) ? `VIG_RST_UART_IDX : j[2:0]);
   end

   always @*
   begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      case (state_r)
         ST_IDLE:
            if (int_enable_i && sel_nxt != `VIG_PRIO_NONE)
               state_nxt = ST_WAIT;
         ST_WAIT:
            // Levels held until sampled; a withdrawn request is dropped
            if (sel_nxt == `VIG_PRIO_NONE)
               state_nxt = ST_IDLE;
            else if (instr_done_i)
            begin
               state_nxt = (sel_nxt == `VIG_PRIO_VECT) ? ST_ACK : ST_DIRECT;
               cnt_nxt   = `VIG_ACK_CYCLES;
            end
         ST_ACK:
            if (cnt_r == 4'h1)
               state_nxt = ST_IDLE;
            else
               cnt_nxt = cnt_r - 4'h1;
         ST_DIRECT:
            state_nxt = ST_IDLE;
         default:
            state_nxt = ST_IDLE;
      endcase
   end

   always @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         state_r           <= ST_IDLE;
         sel_r             <= `VIG_PRIO_NONE;
         cnt_r             <= 4'h0;
         grant_r           <= {NPER{1'b0}};
         vectored_irq_in_o <= 1'b0;
         cpu_ack_n_o       <= 1'b1;
         data_o            <= 8'h00;
         data_oe_o         <= 1'b0;
         vec_taken_o       <= 1'b0;
         vec_addr_o        <= 16'h0000;
         vec_prio_o        <= 3'h0;
      end
      else
      begin
         state_r           <= state_nxt;
         cnt_r             <= cnt_nxt;
         vectored_irq_in_o <= vect_req;
         vec_taken_o       <= 1'b0;
         if (state_r == ST_IDLE || state_r == ST_WAIT)
            sel_r <= sel_nxt;
         if (state_r == ST_WAIT)
            grant_r <= grant_nxt;
         // Acknowledge low only for vectored service
         cpu_ack_n_o <= ~(state_nxt == ST_ACK);
         // Drive only while request and acknowledge both low
         if (state_nxt == ST_ACK && |(grant_now & ~irq_s2_r))
         begin
            data_o    <= op_sel;
            data_oe_o <= 1'b1;
         end
         else
         begin
            data_o    <= 8'h00;
            data_oe_o <= 1'b0;
         end
         if (state_r == ST_ACK && cnt_r == 4'h1)
         begin
            vec_taken_o <= 1'b1;
            vec_addr_o  <= vig_rst_addr(op_sel);
            vec_prio_o  <= `VIG_PRIO_VECT;
         end
         else if (state_r == ST_DIRECT)
         begin
            vec_taken_o <= 1'b1;
            vec_prio_o  <= sel_r;
            case (sel_r)
               `VIG_PRIO_EDGE: vec_addr_o <= `VIG_VEC_EDGE;
               `VIG_PRIO_MID:  vec_addr_o <= `VIG_VEC_MID;
               default:        vec_addr_o <= `VIG_VEC_LOW;
            endcase
         end
      end
   end

endmodule // vig_host

// ===== rtl/vig_defines.vh
// Purpose: Constants for the vectored interrupt glue host side
// Assumes: 8-bit opcode bus, up to eight requesting peripherals
// Notes:   Restart opcodes step by 8 from the first one
`ifndef VIG_DEFINES_VH
`define VIG_DEFINES_VH

`define VIG_RST_BASE_OP    8'hC7
`define VIG_RST_STEP       8'h08
`define VIG_RST_UART_IDX   3'h4
`define VIG_RST_UART_OP    8'hE7
`define VIG_VEC_RST_BASE   16'h0000
`define VIG_VEC_UART       16'h0020
`define VIG_VEC_EDGE       16'h003C
`define VIG_VEC_MID        16'h0034
`define VIG_VEC_LOW        16'h002C
`define VIG_PRIO_EDGE      3'h2
`define VIG_PRIO_MID       3'h3
`define VIG_PRIO_LOW       3'h4
`define VIG_PRIO_VECT      3'h5
`define VIG_PRIO_NONE      3'h7
`define VIG_ACK_CYCLES     4'h2

`endif

// ===== verif/vig_uart_model.sv
// Purpose: Requesting peripherals on the far side of the glue
// Assumes: One cause latch per peripheral
// Notes:   Behavioural
`timescale 1ns/10ps
module vig_uart_model
(
   input  wire logic       clk_i,
   input  wire logic       reset_n_i,
   input  wire logic [7:0] set_i,
   input  wire logic [7:0] clr_i,
   output logic      [7:0] irq_n_o
);
   always @(posedge clk_i)
      if (!reset_n_i)
         irq_n_o <= 8'hFF;
      else
         irq_n_o <= (irq_n_o & ~set_i) | clr_i;
endmodule // vig_uart_model

// ===== verif/vig_host_checker.sv
// Purpose: Port checks of the interrupt glue
// Assumes: One clock domain
// Notes:   Bound to vig_host
`timescale 1ns/10ps
module vig_host_checker #(parameter NPER = 8)
(
   input wire logic            clk_i, reset_n_i, edge_irq_i, mid_irq_i, low_irq_i, instr_done_i, int_enable_i,
   input wire logic [NPER-1:0] uart_irq_n_i,
   input wire logic            vectored_irq_in_o, cpu_ack_n_o, data_oe_o, vec_taken_o,
   input wire logic [7:0]      data_o,
   input wire logic [15:0]     vec_addr_o,
   input wire logic [2:0]      vec_prio_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_ack_end; !cpu_ack_n_o ##1 cpu_ack_n_o; endsequence
   sequence s_req; !(&uart_irq_n_i) [*4]; endsequence
   property p_inv; s_req |-> vectored_irq_in_o; endproperty
   a_inv: assert property (p_inv) else $error("request not presented");
   property p_ack; $fell(cpu_ack_n_o) |=> s_ack_end; endproperty
   a_ack: assert property (p_ack) else $error("ack width wrong");
   property p_oe; data_oe_o |-> !cpu_ack_n_o; endproperty
   a_oe: assert property (p_oe) else $error("buffer outside ack");
   property p_op; data_oe_o |-> data_o[2:0] == 3'h7 && data_o[7:6] == 2'h3; endproperty
   a_op: assert property (p_op) else $error("bad restart opcode");
   property p_off; !data_oe_o |-> data_o == 8'h00; endproperty
   a_off: assert property (p_off) else $error("bus driven while off");
   property p_vend; $rose(cpu_ack_n_o) |-> vec_taken_o && vec_prio_o == 3'h5; endproperty
   a_vend: assert property (p_vend) else $error("vectored take wrong");
   property p_dir; vec_taken_o && vec_prio_o < 3'h5 |-> cpu_ack_n_o && $past(cpu_ack_n_o, 2); endproperty
   a_dir: assert property (p_dir) else $error("direct take acked");
   property p_edge; vec_taken_o && vec_prio_o == 3'h2 |-> vec_addr_o == 16'h003C; endproperty
   a_edge: assert property (p_edge) else $error("edge vector wrong");
   property p_lvl; vec_taken_o && vec_prio_o == 3'h3 |-> vec_addr_o == 16'h0034; endproperty
   a_lvl: assert property (p_lvl) else $error("mid vector wrong");
   property p_pulse; vec_taken_o |=> !vec_taken_o; endproperty
   a_pulse: assert property (p_pulse) else $error("take not a pulse");
endmodule // vig_host_checker
bind vig_host vig_host_checker #(.NPER(NPER)) chk (.clk_i, .reset_n_i, .edge_irq_i, .mid_irq_i, .low_irq_i,
   .instr_done_i, .int_enable_i, .uart_irq_n_i, .vectored_irq_in_o, .cpu_ack_n_o, .data_oe_o, .vec_taken_o,
   .data_o, .vec_addr_o, .vec_prio_o);

// ===== verif/vig_host_bench.sv
// Purpose: Self-checking bench of the interrupt glue
// Assumes: Inputs driven at falling edge
// Notes:   Peripheral model on the request lines
`timescale 1ns/10ps
module vig_host_bench;
   logic        clk_i = 0, reset_n_i = 0, edge_i = 0, mid_i = 0, low_i = 0, done_i = 0, en_i = 1;
   logic [7:0]  set_r = 0, clr_r = 0, op_r;
   wire  [7:0]  irq_n, data;
   wire         irq_in, ack_n, oe, taken;
   wire  [15:0] addr;
   wire  [2:0]  prio;
   int          errors = 0, compares = 0, cycles = 0, ntaken = 0, n;
   vig_host #(.NPER(8)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .uart_irq_n_i(irq_n), .edge_irq_i(edge_i),
      .mid_irq_i(mid_i), .low_irq_i(low_i), .instr_done_i(done_i), .int_enable_i(en_i),
      .vectored_irq_in_o(irq_in), .cpu_ack_n_o(ack_n), .data_o(data), .data_oe_o(oe), .vec_taken_o(taken),
      .vec_addr_o(addr), .vec_prio_o(prio));
   vig_uart_model uart (.clk_i(clk_i), .reset_n_i(reset_n_i), .set_i(set_r), .clr_i(clr_r), .irq_n_o(irq_n));
   initial forever #4 clk_i = ~clk_i;
   always @(negedge clk_i)
   begin
      cycles++;
      if (oe === 1'b1) op_r = data;
      if (taken === 1'b1) ntaken++;
      if (cycles == 4000)
      begin
         errors++;
         stop_test;
      end
   end
   task chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task stop_test;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task serve;
      int k;
      k = ntaken;
      done_i = 1;
      for (n = 0; n < 12 && ntaken == k; n++) @(negedge clk_i);
      done_i = 0;
      chk(ntaken, k + 1);
   endtask
   task vect(input int i);
      op_r = 8'h00;
      set_r[i] = 1;
      @(negedge clk_i) set_r = 0;
      for (n = 0; n < 8 && irq_in !== 1'b1; n++) @(negedge clk_i);
      chk(irq_in, 1);
      serve;
      chk(op_r, 8'hC7 + 8 * i);
      chk(addr, 16'h0000 + 8 * i);
      chk(prio, 3'h5);
      clr_r[i] = 1;
      @(negedge clk_i) clr_r = 0;
      repeat (5) @(negedge clk_i);
      chk(irq_in, 0);
   endtask
   task direct(input int k, input logic [15:0] a, input logic [2:0] p);
      {edge_i, mid_i, low_i} = 3'b100 >> k;
      repeat (4) @(negedge clk_i);
      serve;
      chk(addr, a);
      chk(prio, p);
      {edge_i, mid_i, low_i} = 3'b000;
      repeat (4) @(negedge clk_i);
   endtask
   task pend;
      en_i = 0;
      {mid_i, low_i} = 2'b11;
      repeat (8) @(negedge clk_i);
      chk(ntaken, 0);
      en_i = 1;
      serve;
      chk(prio, 3'h3);
      {mid_i, low_i} = 2'b00;
      repeat (6) @(negedge clk_i);
   endtask
   initial
   begin
      repeat (3) @(negedge clk_i);
      reset_n_i = 1;
      repeat (3) @(negedge clk_i);
      pend;
      direct(0, 16'h003C, 3'h2);
      direct(1, 16'h0034, 3'h3);
      direct(2, 16'h002C, 3'h4);
      for (int i = 0; i < 8; i++) vect(i);
      stop_test;
   end
endmodule // vig_host_bench
